// ===== rtl/clk_ctl_pkg.sv
// constants and types shared by the multiplier clock control block
package clk_ctl_pkg;

    // ---------------------------------------------------------------
    // register map
    // ---------------------------------------------------------------
    localparam logic [7:0] MAIN_CLOCK_CONTROL_ADDR  = 8'h_fd;
    localparam logic [7:0] PIXEL_CLOCK_CONTROL_ADDR = 8'h_fe;
    localparam logic [7:0] CTRL_RESET_VALUE         = 8'h_00;

    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int ENABLE_BIT   = 7;
    localparam int SELECT_BIT   = 6;
    localparam int COUNT_MSB    = 3;
    localparam int COUNT_WIDTH  = 4;
    localparam int RSVD_MSB     = 5;
    localparam int RSVD_LSB     = 4;

    // gap counter load; the glitch-free switch waits one cycle more than this with both clocks gated
    localparam logic [1:0] SWITCH_GAP_CYCLES = 2'h_2;

    // ---------------------------------------------------------------
    // register field layout
    // ---------------------------------------------------------------
    typedef struct packed {
        logic       enable;
        logic       sel;
        logic [1:0] rsvd;
        logic [3:0] count;
    } mult_ctrl_type;

    typedef enum logic [1:0] {
        src_crystal,
        src_gap,
        src_multiplied
    } core_src_type;

endpackage : clk_ctl_pkg

// ===== rtl/mult_clock_control.sv
// register and clock selection logic for two frequency multipliers
`timescale 1ns/1ps

module mult_clock_control
    import clk_ctl_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    input  wire logic       halt,
    input  wire logic       pixel_rate_double,
    input  wire logic       core_mult_stable,
    output logic            core_mult_enable,
    output logic      [3:0] core_mult_count,
    output logic            pixel_mult_enable,
    output logic            pixel_ref_halve,
    output logic      [3:0] pixel_mult_count,
    output logic      [4:0] core_mult_factor,
    output logic      [4:0] pixel_mult_factor,
    output logic            pixel_factor_halved,
    output logic            core_gate_crystal,
    output logic            core_gate_multiplied
);

    // ---------------------------------------------------------------
    // usage notes
    // ---------------------------------------------------------------
    // the block holds two byte-wide control registers on a plain port;
    // writes land on the edge that samples the strobe, reads return
    // registered data in the following cycle and zero at all other times
    //
    // the analog loops are outside: this logic hands them an enable, the
    // programmed count and the feedback ratio, and takes back the lock
    // level of the core loop through a two-flop synchroniser
    //
    // the lock level does not gate the source switch: waiting for lock
    // is left to software, so a premature select hands the core a
    // multiplied clock that may not have settled yet
    //
    // the core clock gates are break-before-make; a short gap with both
    // gates closed costs a few crystal cycles on every switch but keeps
    // runt pulses away from the core
    //
    // halt is a level: every cycle it stands both registers are held at
    // their reset value, and a write in the same cycle is lost
    //
    // reserved bits are dropped on the way in, not masked on the way
    // out, so the stored value itself can never carry a one there
    //
    // counts outside the permitted ranges are stored as written; keeping
    // to the permitted ranges is the duty of software

    // ---------------------------------------------------------------
    // control registers
    // ---------------------------------------------------------------
    mult_ctrl_type main_q;
    mult_ctrl_type main_d;
    mult_ctrl_type pix_q;
    mult_ctrl_type pix_d;
    logic [7:0]    rdata_q;
    logic [7:0]    rdata_d;
    logic          stable_s1_q;
    logic          stable_q;
    core_src_type  src_q;
    core_src_type  src_d;
    logic [1:0]    gap_q;
    logic [1:0]    gap_d;

    // address decode
    wire hit_main = (addr == MAIN_CLOCK_CONTROL_ADDR);
    wire hit_pix  = (addr == PIXEL_CLOCK_CONTROL_ADDR);
    wire wr_main  = wr && hit_main;
    wire wr_pix   = wr && hit_pix;

    // reserved bits are dropped on write so they can never read one
    wire mult_ctrl_type wr_val = '{enable: wdata[ENABLE_BIT],
                                   sel:    wdata[SELECT_BIT],
                                   rsvd:   2'h_0,
                                   count:  wdata[COUNT_MSB:0]};

    // halt wins over a same-cycle write: both registers go to reset
    assign main_d = halt ? mult_ctrl_type'(CTRL_RESET_VALUE)
                  : wr_main ? wr_val : main_q;
    assign pix_d  = halt ? mult_ctrl_type'(CTRL_RESET_VALUE)
                  : wr_pix ? wr_val : pix_q;

    // unmapped addresses read zero
    assign rdata_d = !rd ? 8'h_00
                   : hit_main ? main_q
                   : hit_pix ? pix_q : 8'h_00;

    // register update
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            main_q  <= mult_ctrl_type'(CTRL_RESET_VALUE);
            pix_q   <= mult_ctrl_type'(CTRL_RESET_VALUE);
            rdata_q <= 8'h_00;
        end else begin
            main_q  <= main_d;
            pix_q   <= pix_d;
            rdata_q <= rdata_d;
        end
    end

    assign rdata = rdata_q;

    // ---------------------------------------------------------------
    // multiplier controls
    // ---------------------------------------------------------------
    // both multipliers are independent: each takes its own enable/count
    assign core_mult_enable  = main_q.enable;
    assign core_mult_count   = main_q.count;
    assign pixel_mult_enable = pix_q.enable;
    assign pixel_mult_count  = pix_q.count;
    // software keeps this low; passed through untouched
    assign pixel_ref_halve   = pix_q.sel;

    // feedback divide ratio (count+1); analog loop provides the /2
    assign core_mult_factor    = {1'b0, main_q.count} + 5'h_01;
    assign pixel_mult_factor   = {1'b0, pix_q.count} + 5'h_01;
    assign pixel_factor_halved = !pixel_rate_double;

    // ---------------------------------------------------------------
    // lock indication from the analog side crosses into clk
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stable_s1_q <= 1'b0;
            stable_q    <= 1'b0;
        end else begin
            stable_s1_q <= core_mult_stable;
            stable_q    <= stable_s1_q;
        end
    end

    // ---------------------------------------------------------------
    // glitch-free core source switch
    // ---------------------------------------------------------------
    // want multiplied only with enable set; enable low falls back at once
    wire want_mult = main_q.enable && main_q.sel;

    // break-before-make: both gates closed for a short gap so neither
    // clock can deliver a runt pulse while the other takes over
    always_comb begin
        src_d = src_q;
        gap_d = gap_q;
        unique case (src_q)
            src_crystal: begin
                if (want_mult) begin
                    src_d = src_gap;
                    gap_d = SWITCH_GAP_CYCLES;
                end
            end
            src_gap: begin
                if (gap_q != 2'h_0) begin
                    gap_d = gap_q - 2'h_1;
                end else if (want_mult) begin
                    src_d = src_multiplied;
                end else begin
                    src_d = src_crystal;
                end
            end
            src_multiplied: begin
                if (!want_mult) begin
                    src_d = src_gap;
                    gap_d = SWITCH_GAP_CYCLES;
                end
            end
        endcase
    end

    // source state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            src_q <= src_crystal;
            gap_q <= 2'h_0;
        end else begin
            src_q <= src_d;
            gap_q <= gap_d;
        end
    end

    assign core_gate_crystal    = (src_q == src_crystal);
    assign core_gate_multiplied = (src_q == src_multiplied);

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    // every check is off while reset stands; registers and source state
    // are forced there, so nothing useful can be seen in that time

    // halt leaves both registers at their reset value
    halt_clears_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        halt |=> (main_q == 8'h_00) && (pix_q == 8'h_00))
        else $error("halt did not clear control registers");

    // halt turns both multipliers off on the next edge
    halt_off_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        halt |=> !core_mult_enable && !pixel_mult_enable)
        else $error("multiplier left on through halt");

    // the stored reserved bits never carry a one
    rsvd_zero_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (main_q.rsvd == 2'h_0) && (pix_q.rsvd == 2'h_0))
        else $error("reserved bits not zero");

    // enable low takes the multiplied gate away at the next edge
    fallback_fast_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        !main_q.enable |=> !core_gate_multiplied)
        else $error("multiplied clock kept with enable low");

    // with enable held low the crystal gate is back within the gap
    fallback_done_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (!main_q.enable && !core_gate_multiplied)
        ##1 !main_q.enable [*3] |=> core_gate_crystal)
        else $error("crystal clock not restored in time");

    // never both sources at once
    no_overlap_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        !(core_gate_crystal && core_gate_multiplied))
        else $error("both core clock gates open");

    // after the crystal gate closes, the multiplied gate stays closed for the whole gap
    switch_gap_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        $fell(core_gate_crystal) |-> !core_gate_multiplied [*3])
        else $error("switch gap too short");

    // the gap counter never starts above its load value
    gap_bound_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        gap_q <= SWITCH_GAP_CYCLES)
        else $error("switch gap counter out of range");

    // a held request reaches the multiplied clock after the gap
    switch_done_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (core_gate_crystal && want_mult) ##1 want_mult [*3]
        |=> core_gate_multiplied)
        else $error("multiplied clock not selected in time");

    // the multiplied gate opens only on an enabled select
    select_gated_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        core_gate_multiplied |-> $past(want_mult))
        else $error("multiplied clock without select");

    // a main write lands in the next cycle
    write_main_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (wr_main && !halt) |=> core_mult_count == $past(wdata[3:0])
                           && core_mult_enable == $past(wdata[7]))
        else $error("main control write lost");

    // a pixel write lands in the next cycle
    write_pix_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (wr_pix && !halt) |=> pixel_mult_count == $past(wdata[3:0])
                          && pixel_mult_enable == $past(wdata[7]))
        else $error("pixel control write lost");

    // the main register holds without a write or halt
    main_hold_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (!wr_main && !halt) |=> $stable(main_q))
        else $error("main control changed by itself");

    // the pixel register holds without a write or halt
    pixel_hold_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (!wr_pix && !halt) |=> $stable(pix_q))
        else $error("pixel control changed by itself");

    // core feedback ratio follows the count
    core_factor_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        core_mult_factor == {1'b0, core_mult_count} + 5'h_01)
        else $error("core factor wrong");

    // pixel feedback ratio follows the count
    factor_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        pixel_mult_factor == {1'b0, pixel_mult_count} + 5'h_01)
        else $error("pixel factor wrong");

    // halving is on exactly when the rate is not doubled
    halved_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        pixel_factor_halved != pixel_rate_double)
        else $error("pixel halving wrong");

    // lock level walks the two flops in order
    sync_pipe_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        stable_q == $past(stable_s1_q))
        else $error("lock synchroniser out of order");

    // reads return the addressed register one cycle later
    read_back_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (rd && hit_pix) |=> rdata == $past(pix_q))
        else $error("pixel control read back wrong");

    read_main_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (rd && hit_main) |=> rdata == $past(main_q))
        else $error("main control read back wrong");

endmodule : mult_clock_control

// ===== tb/dual_multiplier_clock_control_tb_top.sv
// self-checking bench for the multiplier clock control block
`timescale 1ns/1ps

module dual_multiplier_clock_control_tb_top;
    import clk_ctl_pkg::*;
    localparam logic [7:0] A_M = MAIN_CLOCK_CONTROL_ADDR;
    localparam logic [7:0] A_P = PIXEL_CLOCK_CONTROL_ADDR;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic [7:0] addr = 8'h_00;
    logic [7:0] wdata = 8'h_00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic       halt = 1'b0;
    logic       pixel_rate_double = 1'b0;
    logic       stable;
    logic [7:0] rdata;
    logic       cm_en, pm_en, p_halve, f_halved, g_x, g_m;
    logic [3:0] cm_cnt, pm_cnt;
    logic [4:0] cm_f, pm_f;
    int         n_mismatch = 0;
    int         n_tests = 0;

    // free-running 100 MHz clock
    always #5 clk = ~clk;

    mult_clock_control dut (.clk(clk), .rst_n(rst_n), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .halt(halt),
        .pixel_rate_double(pixel_rate_double), .core_mult_stable(stable),
        .core_mult_enable(cm_en), .core_mult_count(cm_cnt),
        .pixel_mult_enable(pm_en), .pixel_ref_halve(p_halve),
        .pixel_mult_count(pm_cnt), .core_mult_factor(cm_f),
        .pixel_mult_factor(pm_f), .pixel_factor_halved(f_halved),
        .core_gate_crystal(g_x), .core_gate_multiplied(g_m));

    mult_lock_model lock (.clk(clk), .rst_n(rst_n), .enable(cm_en),
        .stable(stable));

    // ---------------------------------------------------------------
    // bus and compare helpers
    // ---------------------------------------------------------------
    task final_report;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : final_report

    task check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check

    task reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask : reg_wr

    // read data stand only in the cycle after the strobe
    task rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 check(rdata, exp);
    endtask : rd_chk

    task gates(input int n, input logic [1:0] exp);
        repeat (n) @(posedge clk);
        #1 check({6'h_00, g_x, g_m}, {6'h_00, exp});
    endtask : gates

    // software must not select the multiplied clock before lock
    task start_core;
        int i;
        reg_wr(A_M, 8'h_85);
        for (i = 0; i < 50 && stable !== 1'b1; i++) @(posedge clk);
        if (stable !== 1'b1) begin
            n_mismatch++;
            $display("unexpected at %0t: lock wait ran out", $time);
            final_report;
        end
        reg_wr(A_M, 8'h_c5);
    endtask : start_core

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task t_fields;
        int   c;
        int   p;
        logic dbl;
        rd_chk(A_M, 8'h_00);
        rd_chk(A_P, 8'h_00);
        gates(1, 2'b10);
        check({6'h_00, cm_en, pm_en}, 8'h_00);
        reg_wr(A_M, 8'h_7b);
        rd_chk(A_M, 8'h_4b);
        gates(5, 2'b10);
        reg_wr(A_P, 8'h_b9);
        rd_chk(A_P, 8'h_89);
        check({pm_en, p_halve, 2'b00, pm_cnt}, 8'h_89);
        for (c = 4; c <= 11; c++) begin
            reg_wr(A_M, 8'h_80 | c[7:0]);
            check({cm_en, 2'b00, cm_f}, 8'h_81 + c[7:0]);
            p = (c < 6) ? c + 2 : c;
            dbl = p[0] && (p <= 9);
            reg_wr(A_P, 8'h_80 | p[7:0]);
            @(posedge clk);
            pixel_rate_double <= dbl;
            #1 check({f_halved, 2'b00, pm_f}, {~dbl, 2'b00, 5'h_01 + p[4:0]});
        end
        reg_wr(8'h_fc, 8'h_12);
        rd_chk(8'h_fc, 8'h_00);
        rd_chk(A_M, 8'h_8b);
        $display("fields test done");
    endtask : t_fields

    // switch over, then fall back when the multiplier is turned off
    task t_switch;
        start_core;
        gates(1, 2'b00);
        gates(2, 2'b00);
        gates(1, 2'b01);
        reg_wr(A_M, 8'h_45);
        gates(1, 2'b00);
        gates(3, 2'b10);
        reg_wr(A_M, 8'h_05);
        $display("switch test done");
    endtask : t_switch

    task t_halt;
        start_core;
        reg_wr(A_P, 8'h_86);
        gates(5, 2'b01);
        @(posedge clk);
        halt <= 1'b1;
        @(posedge clk);
        halt <= 1'b0;
        #1 check({cm_en, pm_en, cm_cnt, 2'b00}, 8'h_00);
        gates(4, 2'b10);
        rd_chk(A_P, 8'h_00);
        $display("halt test done");
    endtask : t_halt

    // main sequence
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        t_fields;
        t_switch;
        t_halt;
        final_report;
    end

    // guard against a hang anywhere in the run
    initial begin
        #200000;
        n_mismatch++;
        final_report;
    end
endmodule : dual_multiplier_clock_control_tb_top

// ===== tb/mult_lock_model.sv
// lock model of the crystal-referenced core multiplier
`timescale 1ns/1ps

module mult_lock_model #(
    parameter int LOCK_CYCLES = 6
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic enable,
    output logic      stable
);
    logic [7:0] cnt_q;

    // lock only after a settling time; lock is lost at once when disabled
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 8'h_00;
        end else if (!enable) begin
            cnt_q <= 8'h_00;
        end else if (cnt_q != LOCK_CYCLES[7:0]) begin
            cnt_q <= cnt_q + 8'h_01;
        end
    end
    assign stable = (cnt_q == LOCK_CYCLES[7:0]);
endmodule : mult_lock_model
